// ---- inc/fps_pkg.sv ----
// constants, register map and carrier types for the fire pump start supervisor
package fps_pkg;
	// clock and time base
	localparam int          CLK_HZ         = 100_000_000;
	localparam int          SECOND_S       = 1;                  // tick period in seconds
	localparam int          TICK_CYC       = CLK_HZ * SECOND_S;  // cycles per tick
	localparam int          POWER_UP_MAX_S = 10;                 // bound on readiness
	localparam logic [3:0]  SETTLE_S       = 4'h1;               // ticks until ready, below the bound
	// thresholds in percent
	localparam logic [7:0]  PHASE_NOM_PCT  = 8'h55;              // 85 percent
	localparam logic [7:0]  SP_MIN_PCT     = 8'h3a;              // 58 percent
	localparam logic [7:0]  SP_MAX_PCT     = 8'h41;              // 65 percent
	localparam logic [7:0]  OVERPRESS_PCT  = 8'h73;              // 115 percent of set pressure
	// delay limits in seconds
	localparam logic [3:0]  STEP_MIN_S     = 4'h5;
	localparam logic [3:0]  STEP_MAX_S     = 4'ha;
	localparam logic [3:0]  ACCEL_MIN_S    = 4'h1;
	localparam logic [3:0]  ACCEL_MAX_S    = 4'ha;
	// register byte offsets
	localparam logic [31:0] ADDR_CTRL      = 32'h0000_0000;
	localparam logic [31:0] ADDR_THR       = 32'h0000_0004;
	localparam logic [31:0] ADDR_TIME      = 32'h0000_0008;
	localparam logic [31:0] ADDR_STATUS    = 32'h0000_000c;
	// field positions
	localparam int          CTRL_SP_BIT    = 0;
	localparam int          CTRL_VS_BIT    = 1;
	localparam int          CTRL_HZ_BIT    = 2;
	localparam int          CTRL_POS_LSB   = 4;
	localparam int          TIME_SEQ_LSB   = 0;
	localparam int          TIME_HZ_LSB    = 4;
	localparam int          TIME_ACC_LSB   = 8;
	localparam int          STAT_RUN_BIT   = 0;
	localparam int          STAT_INR_BIT   = 1;
	localparam int          STAT_RDY_BIT   = 2;
	localparam int          STAT_EMG_BIT   = 3;
	localparam int          STAT_CLS_LSB   = 4;
	localparam int          STAT_ALM_LSB   = 8;
	// reset values
	localparam logic [31:0] CTRL_RST       = 32'h0000_0000;
	localparam logic [31:0] THR_RST        = 32'h0000_003c;
	localparam logic [31:0] TIME_RST       = 32'h0000_0577;
	// alarm contact indices
	localparam int          ALM_RUN        = 0;
	localparam int          ALM_PHASE      = 1;
	localparam int          ALM_REV        = 2;
	localparam int          ALM_ACLOSS     = 3;
	localparam int          ALM_ALT        = 4;
	localparam int          ALM_DRIVE      = 5;
	localparam int          ALM_BYPASS     = 6;
	localparam int          ALM_OVERP      = 7;
	localparam int          ALM_N          = 8;
	// bus answer codes
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;

	// axi4-lite master to slave
	typedef struct packed {
		logic        awvalid;
		logic [31:0] awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [31:0] araddr;
		logic        rready;
	} fps_axil_req_type;

	// axi4-lite slave to master
	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} fps_axil_rsp_type;

	// contact inputs from the panel and field wiring
	typedef struct packed {
		logic local_start;   // local start pushbutton, high pressed
		logic local_stop;    // local stop pushbutton, high pressed
		logic remote_run_n;  // remote station loop, low demands a run
		logic press_ok;      // pressure switch, low demands a run
		logic emerg_latched; // emergency actuator in full running latch
		logic phase_rev;     // line side phase reversal
		logic ac_ok;         // ac power present
		logic alt_source;    // transfer switch on alternate source
		logic drive_fault;   // variable speed drive failed
		logic bypass_on;     // variable speed drive bypassed
	} fps_pins_type;

	// start sequencer states, one-hot
	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_DELAY = 4'b0010,
		ST_START = 4'b0100,
		ST_RUN   = 4'b1000
	} fps_state_type;

	// demand class that owns the current start
	typedef enum logic [1:0] {
		CLS_NONE   = 2'h0,
		CLS_LOCAL  = 2'h1,
		CLS_REMOTE = 2'h2,
		CLS_AUTO   = 2'h3
	} fps_class_type;
endpackage

// ---- sim/fps_panel.sv ----
// operator panel model: pushbuttons, remote loop, field contacts and analog levels
`timescale 1ns/10ps
module fps_panel
	import fps_pkg::*;
(
	input  wire logic            sys_clk,
	output      fps_pins_type    pins,
	output      logic [2:0][7:0] phase_pct,
	output      logic [7:0]      discharge_pct
);
	// healthy plant at power up: no demand, power good, pressure ok
	initial begin
		pins = '0;
		pins.remote_run_n = 1'b1;
		pins.press_ok = 1'b1;
		pins.ac_ok = 1'b1;
		phase_pct = {3{8'h64}};
		discharge_pct = 8'h64;
	end
	// momentary press, held long enough that the two-flop synchroniser sees it
	task automatic tap(input logic stop);
		@(posedge sys_clk);
		if (stop)
			pins.local_stop <= 1'b1;
		else
			pins.local_start <= 1'b1;
		repeat (6) @(posedge sys_clk);
		pins.local_start <= 1'b0;
		pins.local_stop <= 1'b0;
	endtask
endmodule // fps_panel

// ---- sim/fps_supervisor_bench.sv ----
// self-checking bench for the fire pump start supervisor
`timescale 1ns/10ps
module fps_supervisor_bench
	import fps_pkg::*;
;
	localparam int    TICK = 20;    // short second tick keeps every delay in the hundreds of cycles
	logic             sys_clk;
	logic             sys_rst;
	fps_axil_req_type req;          // bus master side
	fps_axil_rsp_type rsp;          // slave answers
	fps_pins_type     pins;
	logic [2:0][7:0]  phase_pct;
	logic [7:0]       discharge_pct;
	logic             motor_run;
	logic             inrush_start;
	logic [ALM_N-1:0] alarm;
	int               fail_count;
	int               check_count;
	logic [31:0]      rd;           // last read data
	logic [1:0]       rs;           // last response code

	fps_supervisor #(.TICK_CYCLES(TICK)) fps_supervisor_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.axil_req(req), .axil_rsp(rsp), .pins(pins), .phase_pct(phase_pct), .discharge_pct(discharge_pct),
		.motor_run(motor_run), .inrush_start(inrush_start), .alarm(alarm));
	fps_panel fps_panel_i (.sys_clk(sys_clk), .pins(pins), .phase_pct(phase_pct), .discharge_pct(discharge_pct));

	// free-running 100 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	// handshakes are sampled in the settled half cycle just before the edge that takes them
	task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
		logic aw_hs;
		logic w_hs;
		logic done;
		int   n;
		done = 1'b0;
		n = 0;
		@(posedge sys_clk);
		req <= '{awvalid: 1'b1, awaddr: a, wvalid: 1'b1, wdata: d, wstrb: 4'hf, bready: 1'b1, default: '0};
		while (!done && n < 100) begin
			@(negedge sys_clk);
			aw_hs = req.awvalid && rsp.awready;
			w_hs = req.wvalid && rsp.wready;
			done = rsp.bvalid;
			rs = rsp.bresp;
			@(posedge sys_clk);
			if (aw_hs) req.awvalid <= 1'b0;
			if (w_hs) req.wvalid <= 1'b0;
			n++;
		end
		req.bready <= 1'b0;
		check(done, 1'b1);
		check(rs, RESP_OKAY);
	endtask

	task automatic axi_rd(input logic [31:0] a, input logic [31:0] exp, input logic [1:0] resp);
		logic ar_hs;
		logic done;
		int   n;
		done = 1'b0;
		n = 0;
		@(posedge sys_clk);
		req <= '{arvalid: 1'b1, araddr: a, rready: 1'b1, default: '0};
		while (!done && n < 100) begin
			@(negedge sys_clk);
			ar_hs = req.arvalid && rsp.arready;
			done = rsp.rvalid;
			rd = rsp.rdata;
			rs = rsp.rresp;
			@(posedge sys_clk);
			if (ar_hs) req.arvalid <= 1'b0;
			n++;
		end
		req.rready <= 1'b0;
		check(done, 1'b1);
		check(rd, exp);
		check(rs, resp);
	endtask

	// bounded wait for the contactor drive to reach a level
	task automatic wait_run(input logic exp, input int lim);
		int n;
		n = 0;
		@(negedge sys_clk);
		while (motor_run !== exp && n < lim) begin
			@(negedge sys_clk);
			n++;
		end
		check(motor_run, exp);
	endtask

	// one start demand: 0 local, 1 remote, 2 pressure; released early, only local stop ends it
	task automatic demand(input int src, input int quiet, input int lim);
		if (src == 0)
			fps_panel_i.tap(1'b0);
		else if (src == 1)
			@(posedge sys_clk) fps_panel_i.pins.remote_run_n <= 1'b0;
		else
			@(posedge sys_clk) fps_panel_i.pins.press_ok <= 1'b0;
		repeat (quiet) @(negedge sys_clk);
		if (quiet > 0) check(motor_run, 1'b0);
		wait_run(1'b1, lim);
		check(inrush_start, 1'b1);
		check(alarm[ALM_RUN], 1'b1);
		@(posedge sys_clk);
		fps_panel_i.pins.remote_run_n <= 1'b1;
		fps_panel_i.pins.press_ok <= 1'b1;
		repeat (50) @(negedge sys_clk);
		check(motor_run, 1'b1);
		fps_panel_i.tap(1'b1);
		wait_run(1'b0, 20);
		check(alarm[ALM_RUN], 1'b0);
	endtask

	task automatic t_emerg;
		@(posedge sys_clk) fps_panel_i.pins.emerg_latched <= 1'b1;
		wait_run(1'b1, 20);
		check(inrush_start, 1'b0);
		fps_panel_i.tap(1'b1);
		repeat (10) @(negedge sys_clk);
		check(motor_run, 1'b1);
		@(posedge sys_clk) fps_panel_i.pins.emerg_latched <= 1'b0;
		wait_run(1'b0, 20);
	endtask

	// local start while a pressure start waits out its sequential delay
	task automatic t_cut;
		@(posedge sys_clk) fps_panel_i.pins.press_ok <= 1'b0;
		repeat (60) @(negedge sys_clk);
		check(motor_run, 1'b0);
		fps_panel_i.tap(1'b0);
		wait_run(1'b1, 20);
		axi_rd(ADDR_STATUS, 32'h0000_0117, RESP_OKAY);
		@(posedge sys_clk) fps_panel_i.pins.press_ok <= 1'b1;
		fps_panel_i.tap(1'b1);
		wait_run(1'b0, 20);
	endtask

	// analog level: index 0..2 is a phase, 3 the discharge pressure
	task automatic level(input int i, input logic [7:0] v, input int idx, input logic exp);
		@(posedge sys_clk);
		if (i < 3)
			fps_panel_i.phase_pct[i] <= v;
		else
			fps_panel_i.discharge_pct <= v;
		repeat (6) @(negedge sys_clk);
		check(alarm[idx], exp);
	endtask

	// toggle one contact, alarm must follow both ways
	task automatic flip(input fps_pins_type m, input int idx);
		@(posedge sys_clk) fps_panel_i.pins <= fps_panel_i.pins ^ m;
		repeat (6) @(negedge sys_clk);
		check(alarm[idx], 1'b1);
		@(posedge sys_clk) fps_panel_i.pins <= fps_panel_i.pins ^ m;
		repeat (6) @(negedge sys_clk);
		check(alarm[idx], 1'b0);
	endtask

	task automatic t_alarms;
		for (int i = 0; i < 3; i++) begin
			level(i, 8'h54, ALM_PHASE, 1'b1);
			level(i, 8'h55, ALM_PHASE, 1'b0);
		end
		axi_wr(ADDR_CTRL, 32'h0000_0001);
		axi_wr(ADDR_THR, 32'h0000_003a);
		level(0, 8'h3a, ALM_PHASE, 1'b0);
		level(0, 8'h39, ALM_PHASE, 1'b1);
		level(0, 8'h55, ALM_PHASE, 1'b0);
		flip('{phase_rev: 1'b1, default: 1'b0}, ALM_REV);
		flip('{ac_ok: 1'b1, default: 1'b0}, ALM_ACLOSS);
		flip('{alt_source: 1'b1, default: 1'b0}, ALM_ALT);
		axi_wr(ADDR_CTRL, 32'h0000_0002);
		flip('{drive_fault: 1'b1, default: 1'b0}, ALM_DRIVE);
		flip('{bypass_on: 1'b1, default: 1'b0}, ALM_BYPASS);
		level(3, 8'h73, ALM_OVERP, 1'b1);
		level(3, 8'h72, ALM_OVERP, 1'b0);
	endtask

	task automatic results;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// watchdog: the whole sequence needs well under 5000 cycles
	initial begin
		repeat (20000) @(posedge sys_clk);
		fail_count++;
		results();
	end

	// main sequence; the sequential and high-zone step is 7 ticks, so 14 at position 2
	initial begin
		fail_count = 0;
		check_count = 0;
		sys_rst = 1'b1;
		req = '0;
		repeat (8) @(posedge sys_clk);
		sys_rst <= 1'b0;
		repeat (40) @(negedge sys_clk);
		axi_rd(ADDR_CTRL, CTRL_RST, RESP_OKAY);
		axi_rd(ADDR_THR, THR_RST, RESP_OKAY);
		axi_rd(ADDR_TIME, TIME_RST, RESP_OKAY);
		axi_rd(32'h0000_0010, 32'h0, RESP_SLVERR);
		axi_rd(ADDR_STATUS, 32'h0000_0004, RESP_OKAY);
		demand(0, 0, 20);
		demand(1, 0, 20);
		demand(2, 0, 40);
		axi_wr(ADDR_CTRL, 32'h0000_0020);
		demand(2, 180, 420);
		demand(0, 0, 20);
		demand(1, 0, 20);
		t_cut();
		axi_wr(ADDR_CTRL, 32'h0000_0024);
		demand(0, 180, 420);
		demand(1, 180, 420);
		axi_wr(ADDR_CTRL, 32'h0000_0000);
		t_emerg();
		t_alarms();
		results();
	end
endmodule // fps_supervisor_bench

// ---- src/fps_supervisor.sv ----
// fire pump start supervisor: demand arbitration, start sequencing, alarm contacts, axi4-lite registers
`timescale 1ns/10ps
module fps_supervisor
	import fps_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = TICK_CYC  // cycles per second tick, shorten in simulation
) (
	input  wire logic             sys_clk,
	input  wire logic             sys_rst,
	input  wire fps_axil_req_type axil_req,
	output      fps_axil_rsp_type axil_rsp,
	input  wire fps_pins_type     pins,
	input  wire logic [2:0][7:0]  phase_pct,
	input  wire logic [7:0]       discharge_pct,
	output      logic             motor_run,
	output      logic             inrush_start,
	output      logic [ALM_N-1:0] alarm
);

	// clamp a four-bit field into a range
	function automatic logic [3:0] clamp4(input logic [3:0] v, input logic [3:0] lo, input logic [3:0] hi);
		logic [3:0] r;
		r = v;
		if (v < lo) begin
			r = lo;
		end else if (v > hi) begin
			r = hi;
		end
		return r;
	endfunction

	// pin synchronisers and a history stage for edge detection
	fps_pins_type  pin_meta;   // first stage, read only by pin_sync
	fps_pins_type  pin_sync;   // second stage, safe to use
	fps_pins_type  pin_hist;   // previous value of pin_sync

	// software registers
	logic [31:0]   reg_ctrl;   // options and pump position
	logic [31:0]   reg_thr;    // single-phase protection threshold
	logic [31:0]   reg_time;   // step and acceleration seconds

	// sequencer state
	fps_state_type state;
	fps_state_type next_state;
	fps_class_type cls;
	fps_class_type next_cls;
	logic [8:0]    cnt;        // seconds left in delay or acceleration
	logic [8:0]    next_cnt;
	logic [31:0]   pre_cnt;    // prescaler toward the second tick
	logic          tick;       // one cycle per second
	logic [3:0]    boot_cnt;   // seconds since reset, counted only until ready
	logic          ready;      // block fully functional

	// always sync twice; the third stage only feeds edge detectors
	always_ff @(posedge sys_clk) begin
		pin_meta <= pins;
		pin_sync <= pin_meta;
		pin_hist <= pin_sync;
	end

	// decoded demands
	wire logic stop_evt   = pin_sync.local_stop & ~pin_hist.local_stop;
	wire logic local_req  = pin_sync.local_start & ~pin_hist.local_start;   // local momentary class
	wire logic remote_req = ~pin_sync.remote_run_n;  // open loop means run, never blocks others
	wire logic auto_req   = ~pin_sync.press_ok;      // static class; dead switch demands a run
	wire logic man_req    = local_req | remote_req;  // manual accepted beside automatic
	wire logic emerg      = pin_sync.emerg_latched;  // only the operator's full latch counts

	// option fields
	wire logic       sp_prot  = reg_ctrl[CTRL_SP_BIT];
	wire logic       vs_fit   = reg_ctrl[CTRL_VS_BIT];
	wire logic       hz_en    = reg_ctrl[CTRL_HZ_BIT];
	wire logic [3:0] pump_pos = reg_ctrl[CTRL_POS_LSB +: 4];
	wire logic [3:0] seq_s    = clamp4(reg_time[TIME_SEQ_LSB +: 4], STEP_MIN_S, STEP_MAX_S);
	wire logic [3:0] hz_s     = clamp4(reg_time[TIME_HZ_LSB +: 4], STEP_MIN_S, STEP_MAX_S);
	wire logic [3:0] acc_s    = clamp4(reg_time[TIME_ACC_LSB +: 4], ACCEL_MIN_S, ACCEL_MAX_S);

	// accumulated delays: position times per-step seconds
	wire logic [7:0] seq_prod  = {4'h0, pump_pos} * {4'h0, seq_s};
	wire logic [7:0] hz_prod   = hz_en ? {4'h0, pump_pos} * {4'h0, hz_s} : 8'h00;
	wire logic [8:0] man_delay = {1'b0, hz_prod};   // no sequential part for manual starts
	wire logic [8:0] auto_dly  = {1'b0, seq_prod} + {1'b0, hz_prod};

	// phase threshold: fixed nominal, or the clamped option value
	wire logic [7:0] thr_raw   = reg_thr[7:0];
	wire logic [7:0] thr_sp    = (thr_raw < SP_MIN_PCT) ? SP_MIN_PCT :
	                             (thr_raw > SP_MAX_PCT) ? SP_MAX_PCT : thr_raw;
	wire logic [7:0] phase_thr = sp_prot ? thr_sp : PHASE_NOM_PCT;
	logic [2:0]      ph_low;   // per phase below threshold

	// one comparator per phase, independent of the motor state
	genvar gp;
	generate
		for (gp = 0; gp < 3; gp++) begin : g_phase
			assign ph_low[gp] = phase_pct[gp] < phase_thr;
		end
	endgenerate

	// second tick prescaler
	always_ff @(posedge sys_clk) begin
		if (sys_rst || tick) begin
			pre_cnt <= 32'h0000_0000;
		end else begin
			pre_cnt <= pre_cnt + 32'h0000_0001;
		end
	end
	assign tick = (pre_cnt == TICK_CYCLES - 1);

	// power-up settle; ready never falls until the next reset
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			boot_cnt <= 4'h0;
			ready    <= 1'b0;
		end else if (!ready && tick) begin
			boot_cnt <= boot_cnt + 4'h1;
			ready    <= (boot_cnt + 4'h1) >= SETTLE_S;  // well within the power-up bound
		end
	end

	// start sequencer next state
	always_comb begin
		next_state = state;
		next_cls   = cls;
		next_cnt   = cnt;
		unique case (state)
			ST_IDLE: begin
				if (ready && man_req) begin
					next_cls   = local_req ? CLS_LOCAL : CLS_REMOTE;
					next_cnt   = man_delay;                  // skip sequencing
					next_state = ST_DELAY;
				end else if (ready && auto_req) begin
					next_cls   = CLS_AUTO;
					next_cnt   = auto_dly;
					next_state = ST_DELAY;
				end
			end
			ST_DELAY: begin
				if (cls == CLS_AUTO && man_req && man_delay < cnt) begin
					// a manual demand cuts short a pending sequential wait
					next_cls = local_req ? CLS_LOCAL : CLS_REMOTE;
					next_cnt = man_delay;
				end else if (cnt == 9'h000) begin
					next_cnt   = {5'h00, acc_s};             // same reduced-inrush ramp for all
					next_state = ST_START;
				end else if (tick) begin
					next_cnt = cnt - 9'h001;
				end
			end
			ST_START: begin
				if (cnt == 9'h000) begin
					next_state = ST_RUN;
				end else if (tick) begin
					next_cnt = cnt - 9'h001;
				end
			end
			ST_RUN: begin
				// a remote demand during an automatic run is simply absorbed
				next_state = ST_RUN;                          // no automatic stop exists
			end
		endcase
		// only the local stop ends a run
		if (stop_evt && state != ST_IDLE) begin
			next_state = ST_IDLE;
			next_cls   = CLS_NONE;
			next_cnt   = 9'h000;
		end
	end

	// sequencer registers
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state <= ST_IDLE;
			cls   <= CLS_NONE;
			cnt   <= 9'h000;
		end else begin
			state <= next_state;
			cls   <= next_cls;
			cnt   <= next_cnt;
		end
	end

	// contactor drive; emergency bypasses all control state
	wire logic seq_on         = (next_state == ST_START) || (next_state == ST_RUN);
	wire logic next_motor_run = seq_on | emerg;
	wire logic next_inrush    = (next_state == ST_START) & ~emerg;

	// alarm conditions, recomputed every cycle so they clear with the cause
	logic [ALM_N-1:0] next_alarm;
	assign next_alarm[ALM_RUN]    = next_motor_run;
	assign next_alarm[ALM_PHASE]  = |ph_low;
	assign next_alarm[ALM_REV]    = pin_sync.phase_rev;
	assign next_alarm[ALM_ACLOSS] = ~pin_sync.ac_ok;
	assign next_alarm[ALM_ALT]    = pin_sync.alt_source;
	assign next_alarm[ALM_DRIVE]  = vs_fit & pin_sync.drive_fault;
	assign next_alarm[ALM_BYPASS] = vs_fit & pin_sync.bypass_on;
	assign next_alarm[ALM_OVERP]  = vs_fit & (discharge_pct >= OVERPRESS_PCT);

	// output flops
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			motor_run    <= 1'b0;
			inrush_start <= 1'b0;
			alarm        <= '0;
		end else begin
			motor_run    <= next_motor_run;
			inrush_start <= next_inrush;
			alarm        <= next_alarm;
		end
	end

	// axi4-lite write path: address and data held until both are present
	logic        aw_held;
	logic        w_held;
	logic [31:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	wire logic   aw_hs  = axil_req.awvalid & axil_rsp.awready;
	wire logic   w_hs   = axil_req.wvalid & axil_rsp.wready;
	wire logic   b_hs   = axil_rsp.bvalid & axil_req.bready;
	wire logic   wr_do  = aw_held & w_held & ~axil_rsp.bvalid;
	wire logic   wr_ctl = aw_addr == ADDR_CTRL;
	wire logic   wr_thr = aw_addr == ADDR_THR;
	wire logic   wr_tim = aw_addr == ADDR_TIME;
	wire logic   wr_hit = wr_ctl | wr_thr | wr_tim | (aw_addr == ADDR_STATUS);
	wire logic   next_aw_held = (aw_held | aw_hs) & ~wr_do;
	wire logic   next_w_held  = (w_held | w_hs) & ~wr_do;
	logic [31:0] wmask;

	// byte lane mask from the strobes
	genvar gb;
	generate
		for (gb = 0; gb < 4; gb++) begin : g_lane
			assign wmask[gb*8 +: 8] = {8{w_strb[gb]}};
		end
	endgenerate

	// merged write values
	wire logic [31:0] wr_val_ctl = (reg_ctrl & ~wmask) | (w_data & wmask);
	wire logic [31:0] wr_val_thr = (reg_thr & ~wmask) | (w_data & wmask);
	wire logic [31:0] wr_val_tim = (reg_time & ~wmask) | (w_data & wmask);

	// write channel flops
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= 32'h0000_0000;
			w_data  <= 32'h0000_0000;
			w_strb  <= 4'h0;
		end else begin
			aw_held <= next_aw_held;
			w_held  <= next_w_held;
			if (aw_hs) begin
				aw_addr <= axil_req.awaddr;
			end
			if (w_hs) begin
				w_data <= axil_req.wdata;
				w_strb <= axil_req.wstrb;
			end
		end
	end

	// register file; status writes are dropped without error
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			reg_ctrl <= CTRL_RST;
			reg_thr  <= THR_RST;
			reg_time <= TIME_RST;
		end else if (wr_do) begin
			if (wr_ctl) begin
				reg_ctrl <= wr_val_ctl;
			end
			if (wr_thr) begin
				reg_thr <= wr_val_thr;
			end
			if (wr_tim) begin
				reg_time <= wr_val_tim;
			end
		end
	end

	// read decode
	wire logic        ar_hs = axil_req.arvalid & axil_rsp.arready;
	wire logic        r_hs  = axil_rsp.rvalid & axil_req.rready;
	logic [31:0]      status_word;
	assign status_word = {16'h0000, alarm, 2'b00, cls, emerg, ready, inrush_start, motor_run};
	wire logic        rd_ctl = axil_req.araddr == ADDR_CTRL;
	wire logic        rd_thr = axil_req.araddr == ADDR_THR;
	wire logic        rd_tim = axil_req.araddr == ADDR_TIME;
	wire logic        rd_sts = axil_req.araddr == ADDR_STATUS;
	wire logic [31:0] rd_val = rd_ctl ? reg_ctrl : rd_thr ? reg_thr : rd_tim ? reg_time :
	                           rd_sts ? status_word : 32'h0000_0000;

	// response channel flops; one read and one write in flight at most
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			axil_rsp <= '0;
		end else begin
			axil_rsp.awready <= ~next_aw_held;
			axil_rsp.wready  <= ~next_w_held;
			if (wr_do) begin
				axil_rsp.bvalid <= 1'b1;
				axil_rsp.bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (b_hs) begin
				axil_rsp.bvalid <= 1'b0;
			end
			if (ar_hs) begin
				axil_rsp.arready <= 1'b0;
				axil_rsp.rvalid  <= 1'b1;
				axil_rsp.rdata   <= rd_val;
				axil_rsp.rresp   <= (rd_ctl | rd_thr | rd_tim | rd_sts) ? RESP_OKAY : RESP_SLVERR;
			end else if (r_hs || !axil_rsp.rvalid) begin
				axil_rsp.arready <= 1'b1;
				axil_rsp.rvalid  <= 1'b0;
			end
		end
	end

	// checks on the required behaviour
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	chk_local_immediate: assert property (
		(state == ST_IDLE && ready && local_req && !hz_en) ##1 !stop_evt |=> state == ST_START)
		else $error("local start did not begin without delay");
	chk_remote_immediate: assert property (
		(state == ST_IDLE && ready && remote_req && !local_req && !hz_en) ##1 !stop_evt |=> cls == CLS_REMOTE)
		else $error("remote start was not taken at once");
	chk_run_holds: assert property (
		state == ST_RUN && !stop_evt |=> state == ST_RUN)
		else $error("running driver stopped without a local stop");
	chk_emerg_runs: assert property (
		emerg |=> motor_run && !inrush_start)
		else $error("emergency run did not drive the motor");
	chk_emerg_release: assert property (
		!emerg && next_state == ST_IDLE |=> !motor_run)
		else $error("motor stayed on after emergency release");
	chk_phase_nominal: assert property (
		!sp_prot && phase_pct[0] < PHASE_NOM_PCT |=> alarm[ALM_PHASE])
		else $error("phase loss below nominal fraction not flagged");
	chk_phase_sp_band: assert property (
		sp_prot && phase_pct[0] >= SP_MAX_PCT && phase_pct[1] >= SP_MAX_PCT && phase_pct[2] >= SP_MAX_PCT
		|=> !alarm[ALM_PHASE])
		else $error("phase loss flagged above single-phase band");
	chk_vs_gated: assert property (
		!vs_fit |=> alarm[ALM_OVERP:ALM_DRIVE] == 3'b000)
		else $error("variable speed alarm without the option");
	chk_ac_follow: assert property (
		$rose(pin_sync.ac_ok) |=> !alarm[ALM_ACLOSS])
		else $error("power loss alarm did not clear");
	chk_ready_stays: assert property (
		ready |=> ready)
		else $error("ready dropped after power-up");
	// guards a longer settle count creeping past the power-up bound
	chk_ready_bound: assert property (
		!ready |-> boot_cnt < POWER_UP_MAX_S)
		else $error("not ready within the power-up bound");
	chk_start_holds: assert property (
		state != ST_IDLE && !stop_evt |=> state != ST_IDLE)
		else $error("started driver dropped without a local stop");
	chk_stop_ends: assert property (
		stop_evt && state != ST_IDLE && !emerg |=> state == ST_IDLE && !motor_run)
		else $error("local stop did not end the run");
	chk_manual_cut: assert property (
		state == ST_DELAY && cls == CLS_AUTO && local_req && !hz_en && !stop_evt && cnt != 9'h000
		|=> cls == CLS_LOCAL && cnt == 9'h000)
		else $error("local start waited on the sequential delay");

	cov_local_start: cover property (state == ST_IDLE ##1 state == ST_DELAY && cls == CLS_LOCAL);
	cov_auto_delay: cover property (cls == CLS_AUTO && state == ST_DELAY && cnt != 9'h000);
	cov_emerg_run: cover property (emerg && state == ST_IDLE && motor_run);
	cov_run_stop: cover property (state == ST_RUN ##1 state == ST_IDLE);
	cov_manual_cut: cover property (state == ST_DELAY && cls == CLS_AUTO && local_req);

endmodule // fps_supervisor
